/* hdl/dphs_top.sv */
/*
  display value selector with freeze, max tracking and calibration
  request. assumes static mode pins synchronous to ref_clk.
*/
`timescale 1ns/1ps
module dphs_top #(
  parameter int     FULL     = dphs_pkg::FULL_45,   // digit variant
  parameter bit     CAL_CAP  = 1'b1,                // calibration variant
  parameter longint CAL_CYC  = dphs_pkg::CAL_HOLD_CYC // hold cycles
) (
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  input  wire logic                                  hold_in,
  input  wire logic                                  peak_in,
  input  wire logic                                  range_in,
  input  wire logic                                  ratio_valid,
  input  wire logic signed [dphs_pkg::RATIO_W-1:0]   ratio,
  output logic signed [dphs_pkg::CNT_W-1:0]          disp_count,
  output logic                                       disp_update,
  output logic                                       cal_start
);
  if (CAL_CYC < 2) begin : g_bad
    $error("dphs_top: hold count too small");
  end
  // =========================================================
  // synchronisers, two flops each
  logic [2:0] s1;                                  // first stage
  logic [2:0] s2;                                  // second stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
    end else begin
      s1 <= {range_in, peak_in, hold_in};
      s2 <= s1;
    end
  end
  wire logic hold_s  = s2[0];                      // synced freeze
  wire logic peak_s  = s2[1];                      // synced max track
  wire logic range_s = s2[2];                      // synced range
  // =========================================================
  // scaler
  dphs_pkg::dphs_conv_t conv;                      // scaled result
  dphs_scale #(.FULL(FULL)) u_scale (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .ratio_valid (ratio_valid),
    .ratio       (ratio),
    .narrow      (range_s),
    .conv        (conv)
  );
  // =========================================================
  // peak tracking
  logic                             tracking;      // max tracking active
  logic signed [dphs_pkg::CNT_W-1:0] peak_val;     // stored maximum
  wire logic first_peak = peak_s && !tracking && conv.valid;
  wire logic new_peak   = tracking && conv.valid && conv.count > peak_val;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tracking <= 1'b0;
      peak_val <= '0;
    end else if (!peak_s) begin
      tracking <= 1'b0;
      peak_val <= '0;
    end else if (first_peak || new_peak) begin
      tracking <= 1'b1;
      peak_val <= conv.count;                      // first or larger result
    end
  end
  // =========================================================
  // source select: freeze first, then peak, then live
  wire dphs_pkg::dphs_src_t src = hold_s ? dphs_pkg::dphs_src_hold :
                                  peak_s ? dphs_pkg::dphs_src_peak :
                                           dphs_pkg::dphs_src_live;
  logic signed [dphs_pkg::CNT_W-1:0] next_disp;    // next display value
  logic                              next_upd;     // display changes
  always_comb begin
    next_disp = disp_count;
    next_upd  = 1'b0;
    case (src)
      dphs_pkg::dphs_src_hold: begin
        next_disp = disp_count;
      end
      dphs_pkg::dphs_src_peak: begin
        if (first_peak || new_peak) begin
          next_disp = conv.count;
          next_upd  = 1'b1;
        end else if (tracking && disp_count != peak_val) begin
          next_disp = peak_val;                    // freeze released, show maximum
          next_upd  = 1'b1;
        end
      end
      dphs_pkg::dphs_src_live: begin
        if (conv.valid) begin
          next_disp = conv.count;
          next_upd  = 1'b1;
        end
      end
      default: begin
        next_disp = disp_count;
      end
    endcase
  end
  // display register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_count  <= '0;
      disp_update <= 1'b0;
    end else begin
      disp_count  <= next_disp;
      disp_update <= next_upd;
    end
  end
  // =========================================================
  // calibration hold counter
  logic [63:0] hold_cnt;                           // freeze duration
  logic        cal_done;                           // fired this press
  wire logic   cal_hit = CAL_CAP && hold_s && !cal_done && hold_cnt >= 64'(CAL_CYC);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt  <= 64'h0;
      cal_done  <= 1'b0;
      cal_start <= 1'b0;
    end else begin
      hold_cnt  <= hold_s ? hold_cnt + 64'h1 : 64'h0;
      cal_done  <= hold_s && (cal_done || cal_hit);
      cal_start <= cal_hit;
    end
  end
  // =========================================================
  // checks
  a_hold_freezes: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hold_s |=> disp_count == $past(disp_count))
    else $error("display moved while frozen");
  a_peak_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !peak_s |=> !tracking && peak_val == 0)
    else $error("peak not cleared");
  a_peak_mono: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tracking && peak_s |=> peak_val >= $past(peak_val))
    else $error("peak decreased");
  a_peak_grow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    new_peak |=> peak_val == $past(conv.count))
    else $error("peak not replaced");
  a_peak_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
    first_peak && !hold_s |=> disp_count == $past(conv.count) && tracking)
    else $error("first peak not shown");
  a_live_show: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !hold_s && !peak_s && conv.valid |=> disp_count == $past(conv.count) && disp_update)
    else $error("live result not shown");
  a_peak_display: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !hold_s && tracking && peak_s && !new_peak |=> disp_count == $past(peak_val))
    else $error("peak display changed");
  a_hold_no_upd: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hold_s |=> !disp_update)
    else $error("display updated while frozen");
  a_cal_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !hold_s |=> !cal_start)
    else $error("calibration start without freeze");
  a_cal_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cal_start |-> $past(hold_s) && !$past(cal_done) ##1 !cal_start)
    else $error("calibration start wrong");
endmodule : dphs_top

/* hdl/dphs_pkg.sv */
/*
  shared constants and carrier types for the display peak/hold selector.
  assumes a single 25 mhz clock and conversion results delivered as
  signed counts with a one-cycle valid strobe.
*/
// Functional notes
// - freeze held over 2 s starts calibration
// - max tracking shows largest value since start
// - tracking starts from current result as maximum
// - larger new result replaces maximum and display
// - smaller new result changes nothing
// - max input low clears maximum, ends tracking
// - freeze keeps reading from assertion time
// - wide range count is 1.024 times ratio times full
// - negative input adds one to scaled count
// - narrow range multiplies by ten before increment
package dphs_pkg;
  // =========================================================
  // timing
  localparam int  CLK_HZ        = 25000000;      // ref_clk rate
  localparam int  CAL_HOLD_S    = 2;             // freeze time to calibrate
  localparam longint CAL_HOLD_CYC = longint'(CLK_HZ) * CAL_HOLD_S; // cycles
  // =========================================================
  // scaling
  localparam int  FULL_45       = 20000;         // 4.5-digit full scale
  localparam int  FULL_35       = 2000;          // 3.5-digit full scale
  localparam int  GAIN_NUM      = 1024;          // 1.024 as 1024/1000
  localparam int  GAIN_DEN      = 1000;          // gain denominator
  localparam int  NARROW_MUL    = 10;            // narrow-range factor
  localparam int  CNT_W         = 24;            // signed count width
  localparam int  RATIO_W       = 24;            // signed ratio width
  localparam int  RATIO_FRAC    = 20;            // ratio fraction bits
  // =========================================================
  // display source selection
  typedef enum logic [1:0] {
    dphs_src_live  = 2'b00,                      // latest result
    dphs_src_peak  = 2'b01,                      // stored maximum
    dphs_src_hold  = 2'b10                       // frozen reading
  } dphs_src_t;
  // conversion result carrier
  typedef struct packed {
    logic                    valid;              // one-cycle strobe
    logic signed [CNT_W-1:0] count;              // signed result
  } dphs_conv_t;
endpackage : dphs_pkg

/* hdl/dphs_scale.sv */
/*
  count scaler: converts a signed input/reference ratio into a display
  count for either range and digit variant. assumes the ratio arrives as
  a signed fixed-point fraction with a one-cycle valid.
*/
`timescale 1ns/1ps
module dphs_scale #(
  parameter int FULL = dphs_pkg::FULL_45         // full-scale count
) (
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  input  wire logic                                  ratio_valid,
  input  wire logic signed [dphs_pkg::RATIO_W-1:0]   ratio,
  input  wire logic                                  narrow,
  output dphs_pkg::dphs_conv_t                       conv
);
  // =========================================================
  // elaboration check
  if (FULL != dphs_pkg::FULL_45 && FULL != dphs_pkg::FULL_35) begin : g_bad
    $error("dphs_scale: unsupported full scale");
  end
  // =========================================================
  // scaling datapath
  localparam longint K = longint'(dphs_pkg::GAIN_NUM) * FULL;   // gain times full
  wire logic signed [63:0] prod   = 64'(ratio) * K;             // ratio times gain times full
  wire logic signed [63:0] wide   = (prod / dphs_pkg::GAIN_DEN) >>> dphs_pkg::RATIO_FRAC;
  wire logic signed [63:0] ranged = narrow ? wide * dphs_pkg::NARROW_MUL : wide;
  wire logic signed [63:0] fin    = ranged + ((ratio < 0) ? 64'sd1 : 64'sd0);
  // output register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv <= '0;
    end else begin
      conv.valid <= ratio_valid;
      conv.count <= fin[dphs_pkg::CNT_W-1:0];
    end
  end
endmodule : dphs_scale

/* bench/dphs_sw_model.sv */
/*
  front-panel switch model driving the freeze, max-track and range pins.
  assumes the bench states the wanted switch levels; contacts settle on the clock.
*/
`timescale 1ns/1ps
module dphs_sw_model (
  input  wire logic ref_clk,
  input  wire logic want_hold,
  input  wire logic want_peak,
  input  wire logic want_range,
  output logic      hold_in,
  output logic      peak_in,
  output logic      range_in
);
  // ==========================================
  // switch contacts
  initial {hold_in, peak_in, range_in} = 3'h0;
  // levels follow the wanted position one edge later
  always @(posedge ref_clk) begin
    hold_in  <= want_hold;   // a long press asks for calibration
    peak_in  <= want_peak;   // both pressed is a legal panel state
    range_in <= want_range;  // plain level, no bounce
  end
endmodule : dphs_sw_model

/* bench/testbench.sv */
/*
  self-checking bench for the display selector with a behavioural model.
  assumes the design answers two edges after a ratio and syncs pins in two.
*/
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // signals
  logic               ref_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               want_hold, want_peak, want_range;
  logic               hold_in, peak_in, range_in;
  logic               ratio_valid;
  logic signed [23:0] ratio;
  logic signed [23:0] disp_count;
  logic               disp_update, cal_start;
  int                 failures, num_checks, cycles, cal_seen, m_disp, m_pk;
  int                 seed = 82706;
  bit                 m_pk_act;
  // ==========================================
  // clock, timeout and calibration pulse count
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cal_start === 1'b1) cal_seen++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
  dphs_sw_model sw (.ref_clk(ref_clk), .want_hold(want_hold), .want_peak(want_peak),
    .want_range(want_range), .hold_in(hold_in), .peak_in(peak_in), .range_in(range_in));
  dphs_top #(.FULL(dphs_pkg::FULL_45), .CAL_CAP(1'b1), .CAL_CYC(20)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .hold_in(hold_in), .peak_in(peak_in),
    .range_in(range_in), .ratio_valid(ratio_valid), .ratio(ratio),
    .disp_count(disp_count), .disp_update(disp_update), .cal_start(cal_start));
  // ==========================================
  // reporting
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task chk_val(input string what, input logic signed [23:0] exp, input logic signed [23:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_val
  task chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // ==========================================
  // stimulus tasks
  task modes(input logic h, input logic p, input logic r);
    @(posedge ref_clk);
    want_hold  <= h;
    want_peak  <= p;
    want_range <= r;
    if (!p) m_pk_act = 0;      // releasing max-track drops the stored maximum
    if (p && !h && m_pk_act) m_disp = m_pk;  // freeze released: maximum shown again
    repeat (5) @(posedge ref_clk);
  endtask : modes
  // ratio step of 256 is exactly 5 wide-range counts at 20000 full scale
  task send(input int m);
    int   c;
    logic upd;
    logic seen;
    c = want_range ? m * 50 : m * 5;
    if (m < 0) c++;
    upd = 1'b0;
    if (!want_peak && !want_hold) upd = 1'b1;
    else if (want_peak && (!m_pk_act || c > m_pk)) begin
      m_pk_act = 1;
      m_pk     = c;
      upd      = !want_hold;
    end
    if (upd) m_disp = c;
    @(posedge ref_clk);
    ratio_valid <= 1'b1;
    ratio       <= 24'(m * 256);
    @(posedge ref_clk);
    ratio_valid <= 1'b0;
    ratio       <= 24'($random(seed));
    seen = 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      if (disp_update === 1'b1) seen = 1'b1;
    end
    chk_bit("disp_update", upd, seen);
    chk_val("disp_count", 24'(m_disp), disp_count);
  endtask : send
  // ==========================================
  // main sequence
  initial begin
    {want_hold, want_peak, want_range, ratio_valid} = 4'h0;
    ratio = 24'h000000;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      modes(1'b0, 1'b0, i[0]);
      send($random(seed) % 4000);
    end
    $display("live ranges done");
    modes(1'b0, 1'b1, 1'b0);
    send(5); send(3); send(9); send(9); send(-4); send(12);
    modes(1'b0, 1'b0, 1'b0);
    send(2);
    modes(1'b0, 1'b1, 1'b0);
    send(1);
    $display("peak tracking done");
    modes(1'b0, 1'b0, 1'b0);
    send(7);
    modes(1'b1, 1'b0, 1'b0);
    send(50);
    modes(1'b1, 1'b1, 1'b0);
    send(60);
    modes(1'b1, 1'b0, 1'b0);
    modes(1'b0, 1'b0, 1'b0);
    modes(1'b1, 1'b0, 1'b0);
    modes(1'b0, 1'b0, 1'b0);
    modes(1'b1, 1'b1, 1'b0);
    send(8);
    modes(1'b0, 1'b1, 1'b0);
    @(negedge ref_clk);
    chk_val("disp_count peak after freeze", 24'(m_disp), disp_count);
    modes(1'b0, 1'b0, 1'b0);
    chk_val("cal_start pulses", 24'(1), 24'(cal_seen));
    $display("hold and calibration done");
    test_done();
  end
endmodule : testbench
